// file: src/ijbl_defs.svh
/*
  Encoding fields, opcodes and widths for the indexed jump and byte load unit.
  Included by the package and the unit; definitions only.
*/
`ifndef IJBL_DEFS_SVH
`define IJBL_DEFS_SVH

`define IJBL_XLEN          64
`define IJBL_OP_HI         31
`define IJBL_OP_LO         26
`define IJBL_RT_HI         25
`define IJBL_RT_LO         21
`define IJBL_RS_HI         20
`define IJBL_RS_LO         16
`define IJBL_IMM16_HI      15
`define IJBL_SUB_HI        15
`define IJBL_SUB_LO        12
`define IJBL_FN_HI         11
`define IJBL_FN_LO         9
`define IJBL_IMM9_HI       8
`define IJBL_OP_JUMP_IDX   6'h20
`define IJBL_OP_LB         6'h07
`define IJBL_OP_LBU        6'h05
`define IJBL_OP_POOL_LS    6'h18
`define IJBL_SUB_USER_LD   4'h6
`define IJBL_FN_USER_LB    3'h4
`define IJBL_JUMP_RT_ZERO  5'h00

`endif

// file: src/ijbl_pkg.sv
/*
  Types for the indexed jump and byte load unit.
  Assumes ijbl_defs.svh is on the include path.
*/
`include "ijbl_defs.svh"

package ijbl_pkg;
  typedef logic [`IJBL_XLEN-1:0] ijbl_word_t;
  typedef logic [4:0]            ijbl_reg_t;

  typedef enum logic [2:0] {
    IJBL_OP_NONE  = 3'b000,
    IJBL_OP_JUMP  = 3'b001,
    IJBL_OP_LB    = 3'b010,
    IJBL_OP_ULB   = 3'b011,
    IJBL_OP_LBU   = 3'b100,
    IJBL_OP_RSVD  = 3'b101
  } ijbl_op_t;

  typedef enum logic [1:0] {
    IJBL_ST_IDLE = 2'b00,
    IJBL_ST_LOAD = 2'b01
  } ijbl_state_t;

  typedef enum logic [2:0] {
    IJBL_EXC_NONE     = 3'b000,
    IJBL_EXC_REFILL   = 3'b001,
    IJBL_EXC_INVALID  = 3'b010,
    IJBL_EXC_BUS      = 3'b011,
    IJBL_EXC_ADDR     = 3'b100,
    IJBL_EXC_WATCH    = 3'b101,
    IJBL_EXC_RSVD     = 3'b110,
    IJBL_EXC_COP_UNUS = 3'b111
  } ijbl_exc_t;
endpackage

// file: src/ijbl_unit.sv
/*
  Decode and execute for the indexed compact jump and the three byte loads.
  Sits after instruction decode with register operands already read; talks
  to the translation/load pipeline through a request/response handshake.
*/
// Notes on behaviour
// - Jump: opcode 100000, bits 25..21 zero
// - Target is register plus unshifted sign-extended offset
// - Without 64-bit set: bit0 zero faults at fetch
// - With 64-bit set: bit0 to mode, align check
// - Jump has no delay slot
// - Any instruction may follow a jump
// - Signed byte load: opcode 000111, fields
// - Signed load sign-extends addressed byte
// - Byte lane via endian XOR of address
// - Signed load: refill, invalid, address, watch only
// - User load: opcode 011000, 0110, 100, 9-bit
// - User load uses user mapping in kernel
// - User load exists only with enhanced addressing
// - User load needs coprocessor access, user segment
// - User load full exception set
// - Unsigned byte load: opcode 000101, fields
// - Unsigned load zero-extends addressed byte
`timescale 1ns/1ps
`include "ijbl_defs.svh"

module ijbl_unit (
  input  wire logic               i_clock,
  input  wire logic               i_nrst,
  input  wire logic               i_instr_valid,
  output logic                    o_instr_ready,
  input  wire logic [31:0]        i_instr,
  input  wire ijbl_pkg::ijbl_word_t i_source_reg_value,
  input  wire logic               i_has_64bit_set,
  input  wire logic               i_single_instr_set_flag,
  input  wire logic               i_enhanced_va_present_flag,
  input  wire logic               i_cop0_access_enabled,
  input  wire logic               i_reversed_byte_order_flag,
  input  wire logic               i_high_byte_first_flag,
  output logic                    o_mem_req_valid,
  input  wire logic               i_mem_req_ready,
  output ijbl_pkg::ijbl_word_t    o_mem_vaddr,
  output logic                    o_mem_user_map,
  output logic [2:0]              o_mem_paddr_xor,
  input  wire logic               i_mem_rsp_valid,
  input  wire logic [63:0]        i_mem_rsp_data,
  input  wire logic               i_mem_user_segment,
  input  wire ijbl_pkg::ijbl_exc_t i_mem_rsp_exc,
  output logic                    o_jump_taken,
  output ijbl_pkg::ijbl_word_t    o_jump_target,
  output logic                    o_instr_set_select_bit,
  output logic                    o_target_fetch_fault,
  output logic                    o_flush_next,
  output logic                    o_wb_valid,
  output ijbl_pkg::ijbl_reg_t     o_wb_reg,
  output ijbl_pkg::ijbl_word_t    o_wb_data,
  output logic                    o_exc_valid,
  output ijbl_pkg::ijbl_exc_t     o_exc_code
);
  import ijbl_pkg::*;

  // ==========================================================
  // Helpers
  function automatic ijbl_word_t sext16(input logic [15:0] v);
    sext16 = {{(`IJBL_XLEN-16){v[15]}}, v};
  endfunction

  function automatic ijbl_word_t sext9(input logic [8:0] v);
    sext9 = {{(`IJBL_XLEN-9){v[8]}}, v};
  endfunction

  // ==========================================================
  // Decode
  ijbl_op_t   op;
  logic [5:0] major;
  ijbl_reg_t  rt_field;
  ijbl_word_t ea;
  ijbl_word_t jtarget;

  assign major    = i_instr[`IJBL_OP_HI:`IJBL_OP_LO];
  assign rt_field = i_instr[`IJBL_RT_HI:`IJBL_RT_LO];

  always_comb begin
    op = IJBL_OP_NONE;
    if (major == `IJBL_OP_JUMP_IDX && rt_field == `IJBL_JUMP_RT_ZERO) begin
      op = IJBL_OP_JUMP;
    end else if (major == `IJBL_OP_LB) begin
      op = IJBL_OP_LB;
    end else if (major == `IJBL_OP_LBU) begin
      op = IJBL_OP_LBU;
    end else if (major == `IJBL_OP_POOL_LS
                 && i_instr[`IJBL_SUB_HI:`IJBL_SUB_LO] == `IJBL_SUB_USER_LD
                 && i_instr[`IJBL_FN_HI:`IJBL_FN_LO] == `IJBL_FN_USER_LB) begin
      // Absent feature decodes as reserved
      op = i_enhanced_va_present_flag ? IJBL_OP_ULB : IJBL_OP_RSVD;
    end
  end

  // Unshifted offset add, bit aligned
  assign jtarget = i_source_reg_value + sext16(i_instr[`IJBL_IMM16_HI:0]);
  assign ea = (op == IJBL_OP_ULB) ? i_source_reg_value + sext9(i_instr[`IJBL_IMM9_HI:0])
                                  : i_source_reg_value + sext16(i_instr[`IJBL_IMM16_HI:0]);

  // ==========================================================
  // Load sequencing
  ijbl_state_t state_q;
  ijbl_op_t    ld_op_q;
  ijbl_reg_t   ld_reg_q;
  logic [2:0]  ld_lane_q;
  logic        req_pend_q;
  logic        accept;
  logic        is_load;

  assign is_load       = (op == IJBL_OP_LB) || (op == IJBL_OP_LBU) || (op == IJBL_OP_ULB);
  // Back-to-back accepted except while a load waits for its response, a jump never blocks the next
  assign o_instr_ready = (state_q == IJBL_ST_IDLE);
  assign accept        = i_instr_valid && o_instr_ready;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= IJBL_ST_IDLE;
    end else begin
      case (state_q)
        IJBL_ST_IDLE: begin
          if (accept && is_load && !(op == IJBL_OP_ULB && !i_cop0_access_enabled)) begin
            state_q <= IJBL_ST_LOAD;
          end
        end
        IJBL_ST_LOAD: begin
          if (i_mem_rsp_valid && !req_pend_q) begin
            state_q <= IJBL_ST_IDLE;
          end
        end
        default: state_q <= IJBL_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ld_op_q         <= IJBL_OP_NONE;
      ld_reg_q        <= 5'h00;
      ld_lane_q       <= 3'h0;
      o_mem_vaddr     <= '0;
      o_mem_user_map  <= 1'b0;
      o_mem_paddr_xor <= 3'h0;
    end else if (accept && is_load) begin
      ld_op_q         <= op;
      ld_reg_q        <= rt_field;
      ld_lane_q       <= ea[2:0] ^ {3{i_high_byte_first_flag}};
      o_mem_vaddr     <= ea;
      o_mem_user_map  <= (op == IJBL_OP_ULB);
      o_mem_paddr_xor <= {3{i_reversed_byte_order_flag}};
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      req_pend_q <= 1'b0;
    end else if (accept && is_load && !(op == IJBL_OP_ULB && !i_cop0_access_enabled)) begin
      req_pend_q <= 1'b1;
    end else if (i_mem_req_ready) begin
      req_pend_q <= 1'b0;
    end
  end
  assign o_mem_req_valid = req_pend_q;

  // ==========================================================
  // Jump execution
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_jump_taken           <= 1'b0;
      o_jump_target          <= '0;
      o_instr_set_select_bit <= 1'b0;
      o_target_fetch_fault   <= 1'b0;
      o_flush_next           <= 1'b0;
    end else begin
      o_jump_taken <= accept && (op == IJBL_OP_JUMP);
      o_flush_next <= accept && (op == IJBL_OP_JUMP);
      if (accept && op == IJBL_OP_JUMP) begin
        if (i_single_instr_set_flag) begin
          o_jump_target        <= jtarget;
          o_target_fetch_fault <= 1'b0;
        end else if (i_has_64bit_set) begin
          o_jump_target          <= {jtarget[`IJBL_XLEN-1:1], 1'b0};
          o_instr_set_select_bit <= jtarget[0];
          o_target_fetch_fault   <= !jtarget[0] && jtarget[1];
        end else begin
          o_jump_target          <= {jtarget[`IJBL_XLEN-1:1], 1'b0};
          o_instr_set_select_bit <= jtarget[0];
          // Fault is flagged for the fetch stage to raise
          o_target_fetch_fault   <= !jtarget[0];
        end
      end
    end
  end

  // ==========================================================
  // Writeback and exceptions
  logic [7:0] lane_byte;
  logic       rsp_take;
  logic       exc_allowed;

  assign lane_byte = i_mem_rsp_data[8*ld_lane_q +: 8];
  assign rsp_take  = (state_q == IJBL_ST_LOAD) && i_mem_rsp_valid && !req_pend_q;

  always_comb begin
    exc_allowed = 1'b0;
    case (i_mem_rsp_exc)
      IJBL_EXC_REFILL, IJBL_EXC_INVALID, IJBL_EXC_ADDR, IJBL_EXC_WATCH: exc_allowed = 1'b1;
      IJBL_EXC_BUS: exc_allowed = (ld_op_q == IJBL_OP_ULB);
      default: exc_allowed = 1'b0;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wb_valid  <= 1'b0;
      o_wb_reg    <= 5'h00;
      o_wb_data   <= '0;
      o_exc_valid <= 1'b0;
      o_exc_code  <= IJBL_EXC_NONE;
    end else begin
      o_wb_valid  <= 1'b0;
      o_exc_valid <= 1'b0;
      if (accept && op == IJBL_OP_RSVD) begin
        o_exc_valid <= 1'b1;
        o_exc_code  <= IJBL_EXC_RSVD;
      end else if (accept && op == IJBL_OP_ULB && !i_cop0_access_enabled) begin
        o_exc_valid <= 1'b1;
        o_exc_code  <= IJBL_EXC_COP_UNUS;
      end else if (rsp_take) begin
        if (i_mem_rsp_exc != IJBL_EXC_NONE && exc_allowed) begin
          o_exc_valid <= 1'b1;
          o_exc_code  <= i_mem_rsp_exc;
        end else if (ld_op_q == IJBL_OP_ULB && !i_mem_user_segment) begin
          o_exc_valid <= 1'b1;
          o_exc_code  <= IJBL_EXC_ADDR;
        end else begin
          o_wb_valid <= 1'b1;
          o_wb_reg   <= ld_reg_q;
          if (ld_op_q == IJBL_OP_LBU) begin
            o_wb_data <= {{(`IJBL_XLEN-8){1'b0}}, lane_byte};
          end else begin
            o_wb_data <= {{(`IJBL_XLEN-8){lane_byte[7]}}, lane_byte};
          end
        end
      end
    end
  end

endmodule

// file: verif/ijbl_checker.sv
/* Port checker for ijbl_unit, bound below.
   Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ps
`include "ijbl_defs.svh"
module ijbl_checker (
  input wire logic                 i_clock, i_nrst, i_instr_valid, o_instr_ready, i_single_instr_set_flag,
  input wire logic                 i_enhanced_va_present_flag, i_cop0_access_enabled, i_reversed_byte_order_flag,
  input wire logic                 o_mem_req_valid, o_mem_user_map, o_jump_taken, o_instr_set_select_bit,
  input wire logic                 o_flush_next, o_wb_valid, o_exc_valid,
  input wire logic [31:0]          i_instr,
  input wire logic [2:0]           o_mem_paddr_xor,
  input wire ijbl_pkg::ijbl_word_t i_source_reg_value, o_mem_vaddr, o_jump_target,
  input wire ijbl_pkg::ijbl_exc_t  o_exc_code
);
  import ijbl_pkg::*;
  // ==========================================
  // Decode of the accepted instruction
  wire logic       acc = i_instr_valid && o_instr_ready;
  wire logic [5:0] op  = i_instr[31:26];
  wire logic       jmp = acc && op == `IJBL_OP_JUMP_IDX && i_instr[25:21] == `IJBL_JUMP_RT_ZERO;
  wire logic       ld  = acc && (op == `IJBL_OP_LB || op == `IJBL_OP_LBU);
  wire logic       usr = acc && op == `IJBL_OP_POOL_LS && i_instr[15:9] == 7'h34;
  wire logic       ok  = i_enhanced_va_present_flag && i_cop0_access_enabled;
  wire ijbl_word_t e16 = i_source_reg_value + {{48{i_instr[15]}}, i_instr[15:0]};
  wire ijbl_word_t e9  = i_source_reg_value + {{55{i_instr[8]}}, i_instr[8:0]};
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);
  jump_pulse_a: assert property (jmp |=> o_jump_taken && o_flush_next) else $error("no jump pulse");
  jump_sum_a: assert property (jmp |=> o_jump_target[63:1] == $past(e16[63:1])) else $error("bad sum");
  jump_mode_a: assert property (jmp && !i_single_instr_set_flag |=>
    !o_jump_target[0] && o_instr_set_select_bit == $past(e16[0])) else $error("bad mode split");
  jump_quiet_a: assert property (o_jump_taken |-> !o_wb_valid && !o_exc_valid && !o_mem_req_valid)
    else $error("jump side effect");
  load_addr_a: assert property (ld |=> o_mem_req_valid && !o_mem_user_map && o_mem_vaddr == $past(e16))
    else $error("bad load address");
  user_addr_a: assert property (usr && ok |=> o_mem_req_valid && o_mem_user_map && o_mem_vaddr == $past(e9))
    else $error("bad user address");
  user_cop_a: assert property (usr && i_enhanced_va_present_flag && !i_cop0_access_enabled |=>
    o_exc_valid && o_exc_code == IJBL_EXC_COP_UNUS && !o_mem_req_valid) else $error("cop gate missed");
  lane_mask_a: assert property (ld |=> o_mem_paddr_xor == {3{$past(i_reversed_byte_order_flag)}})
    else $error("bad lane mask");
  cover property (jmp && i_single_instr_set_flag);
  cover property (usr && ok);
  cover property (o_wb_valid);
endmodule
bind ijbl_unit ijbl_checker u_chk (.i_clock, .i_nrst, .i_instr_valid, .o_instr_ready, .i_single_instr_set_flag,
  .i_enhanced_va_present_flag, .i_cop0_access_enabled, .i_reversed_byte_order_flag, .o_mem_req_valid,
  .o_mem_user_map, .o_jump_taken, .o_instr_set_select_bit, .o_flush_next, .o_wb_valid, .o_exc_valid, .i_instr,
  .o_mem_paddr_xor, .i_source_reg_value, .o_mem_vaddr, .o_jump_target, .o_exc_code);

// file: verif/ijbl_mem_model.sv
/* Far-side load pipeline: takes one request, answers after a set delay.
   Delay, data and fault code are levels held by the bench. */
`timescale 1ns/1ps
module ijbl_mem_model (
  input  wire logic                i_clock, i_nrst, i_req_valid,
  input  wire logic [1:0]          i_delay,
  input  wire logic [63:0]         i_data,
  input  wire ijbl_pkg::ijbl_exc_t i_exc,
  output logic                     o_req_ready, o_rsp_valid,
  output logic [63:0]              o_rsp_data,
  output ijbl_pkg::ijbl_exc_t      o_rsp_exc
);
  import ijbl_pkg::*;
  // ==========================================
  // Handoff and answer
  logic [1:0] wait_q;
  logic       busy_q;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      {wait_q, busy_q, o_req_ready, o_rsp_valid, o_rsp_data} <= '0;
      o_rsp_exc <= IJBL_EXC_NONE;
    end else begin
      o_rsp_valid <= 1'b0;
      o_rsp_data  <= ~o_rsp_data;  // Churns so stale data never matches
      o_rsp_exc   <= IJBL_EXC_NONE;
      if (o_req_ready) begin
        {o_req_ready, busy_q, wait_q} <= {2'b01, i_delay};
      end else if (wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end else if (busy_q) begin
        {busy_q, o_rsp_valid, o_rsp_data, o_rsp_exc} <= {2'b01, i_data, i_exc};
      end else begin
        o_req_ready <= i_req_valid;
      end
    end
  end
endmodule

// file: verif/tb.sv
/* Bench for ijbl_unit: random jumps and byte loads against a reference model.
   Far side is ijbl_mem_model; the checker binds itself to the unit. */
`timescale 1ns/1ps
`include "ijbl_defs.svh"
module tb;
  import ijbl_pkg::*;
  logic        i_clock, i_nrst, i_instr_valid, o_instr_ready, i_mem_req_ready, o_mem_req_valid, i_mem_rsp_valid;
  logic        i_has_64bit_set, i_single_instr_set_flag, i_enhanced_va_present_flag, i_cop0_access_enabled;
  logic        i_reversed_byte_order_flag, i_high_byte_first_flag, i_mem_user_segment, o_jump_taken, rmode;
  logic        o_instr_set_select_bit, o_target_fetch_fault, o_flush_next, o_wb_valid, o_exc_valid;
  logic [1:0]  dly;
  logic [31:0] i_instr, seed, r;
  logic [63:0] i_mem_rsp_data, mdata;
  ijbl_word_t  i_source_reg_value, o_jump_target, o_wb_data;
  ijbl_reg_t   o_wb_reg;
  ijbl_exc_t   i_mem_rsp_exc, o_exc_code, mexc;
  int          fails, cmp_count, cycles;
  ijbl_unit u_dut (.i_clock, .i_nrst, .i_instr_valid, .o_instr_ready, .i_instr, .i_source_reg_value,
    .i_has_64bit_set, .i_single_instr_set_flag, .i_enhanced_va_present_flag, .i_cop0_access_enabled,
    .i_reversed_byte_order_flag, .i_high_byte_first_flag, .o_mem_req_valid, .i_mem_req_ready, .o_mem_vaddr(),
    .o_mem_user_map(), .o_mem_paddr_xor(), .i_mem_rsp_valid, .i_mem_rsp_data, .i_mem_user_segment,
    .i_mem_rsp_exc, .o_jump_taken, .o_jump_target, .o_instr_set_select_bit, .o_target_fetch_fault,
    .o_flush_next, .o_wb_valid, .o_wb_reg, .o_wb_data, .o_exc_valid, .o_exc_code);
  ijbl_mem_model u_mem (.i_clock, .i_nrst, .i_req_valid(o_mem_req_valid), .i_delay(dly), .i_data(mdata),
    .i_exc(mexc), .o_req_ready(i_mem_req_ready), .o_rsp_valid(i_mem_rsp_valid), .o_rsp_data(i_mem_rsp_data),
    .o_rsp_exc(i_mem_rsp_exc));
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 4000) begin  // About nine times the expected run
      fails++;
      give_verdict();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // One instruction through the unit and the reference model
  task automatic run(input logic [31:0] ins);
    logic [63:0] ea, e;
    logic [2:0]  ln;
    ijbl_exc_t   ex;
    logic        usr;
    usr = ins[31:26] == `IJBL_OP_POOL_LS;
    ea = i_source_reg_value + (usr ? {{55{ins[8]}}, ins[8:0]} : {{48{ins[15]}}, ins[15:0]});
    ln = ea[2:0] ^ {3{i_high_byte_first_flag}};
    ex = (usr || mexc inside {IJBL_EXC_REFILL, IJBL_EXC_INVALID, IJBL_EXC_ADDR, IJBL_EXC_WATCH}) ? mexc : IJBL_EXC_NONE;
    if (usr && !i_mem_user_segment) ex = IJBL_EXC_ADDR;
    if (usr && !i_cop0_access_enabled) ex = IJBL_EXC_COP_UNUS;
    if (usr && !i_enhanced_va_present_flag) ex = IJBL_EXC_RSVD;
    i_instr = ins;
    while (!o_instr_ready) @(posedge i_clock) #1;
    @(posedge i_clock) #1;
    i_instr = 32'h0;
    for (int n = 0; n < 12 && o_jump_taken !== 1'b1 && o_wb_valid !== 1'b1 && o_exc_valid !== 1'b1; n++)
      @(posedge i_clock) #1;
    if (ins[31:26] == `IJBL_OP_JUMP_IDX) begin
      e = i_single_instr_set_flag ? ea : {ea[63:1], 1'b0};
      if (!i_single_instr_set_flag) rmode = ea[0];
      chk(o_jump_target, e);
      chk(o_instr_set_select_bit, rmode);
      chk(o_target_fetch_fault, !i_single_instr_set_flag && !ea[0] && (!i_has_64bit_set || ea[1]));
      chk({o_flush_next, o_wb_valid, o_exc_valid}, 3'h4);
    end else if (ex != IJBL_EXC_NONE) begin
      chk({o_exc_valid, o_exc_code}, {1'b1, ex});
    end else begin
      e = {56'h0, mdata[8*ln +: 8]};
      if (ins[31:26] != `IJBL_OP_LBU) e = {{56{e[7]}}, e[7:0]};
      chk({o_wb_valid, o_wb_reg}, {1'b1, ins[25:21]});
      chk(o_wb_data, e);
    end
  endtask
  initial begin
    seed = 32'h3159e26e;
    {i_nrst, i_instr_valid, i_instr, i_source_reg_value, dly, mdata, rmode} = '0;
    {i_has_64bit_set, i_single_instr_set_flag, i_enhanced_va_present_flag, i_cop0_access_enabled} = '0;
    {i_reversed_byte_order_flag, i_high_byte_first_flag, i_mem_user_segment} = '0;
    mexc = IJBL_EXC_NONE;
    repeat (4) @(posedge i_clock);
    #1 i_nrst = 1'b1;
    i_instr_valid = 1'b1;
    for (int k = 0; k < 96; k++) begin
      r = $random(seed);
      {i_has_64bit_set, i_single_instr_set_flag, i_reversed_byte_order_flag, i_high_byte_first_flag, dly} = r[5:0];
      i_source_reg_value = {$random(seed), $random(seed)};
      mdata = {$random(seed), $random(seed)};
      i_enhanced_va_present_flag = k % 16 != 3;
      i_cop0_access_enabled = k % 16 != 11;
      i_mem_user_segment = k % 16 != 7;
      mexc = i_mem_user_segment ? ijbl_exc_t'(3'(k % 6)) : IJBL_EXC_NONE;
      case (k % 4)
        0: run({`IJBL_OP_JUMP_IDX, `IJBL_JUMP_RT_ZERO, r[20:0]});
        1: run({`IJBL_OP_LB, r[25:0]});
        2: run({`IJBL_OP_LBU, r[25:0]});
        default: run({`IJBL_OP_POOL_LS, r[25:16], 7'h34, r[8:0]});
      endcase
    end
    give_verdict();
  end
endmodule
